// ---- dv/dpram_chk_sva.sv ----
// port checker for dpram_core: read data, hit flag, ready and byte zero-fill
// assumes one clock, the synchronous active-high reset and the ram's size parameter
`timescale 1ns/100ps
module dpram_chk
	import dpram_pkg::*;
#(
	parameter int unsigned SIZE_BYTES = DPRAM_SIZE_LARGE
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [DPRAM_ADDR_W-1:0] cpu_effective_byte_address,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic cpu_byte,
	input wire logic [DPRAM_DATA_W-1:0] cpu_wdata,
	input wire logic [DPRAM_DATA_W-1:0] cpu_rdata,
	input wire logic cpu_hit,
	input wire logic cpu_ready,
	input wire logic dma_rd,
	input wire logic dma_byte,
	input wire logic [DPRAM_DATA_W-1:0] dma_rdata
);
	// ***************************************************
	// window
	// ***************************************************
	localparam logic [DPRAM_ADDR_W-1:0] BASE =
		DPRAM_ADDR_W'(32'(DPRAM_SPACE_TOP) - SIZE_BYTES);
	logic cpu_in;
	// processor address inside the ram window
	assign cpu_in = (cpu_effective_byte_address >= BASE) &&
		(cpu_effective_byte_address < DPRAM_SPACE_TOP);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ***************************************************
	// properties
	// ***************************************************
	// word write, then word read of the same address in the next cycle
	sequence s_word_wr;
		cpu_wr && !cpu_byte && cpu_in;
	endsequence
	sequence s_word_rd_same;
		cpu_rd && !cpu_wr && !cpu_byte && $stable(cpu_effective_byte_address);
	endsequence
	property p_rdy; !rst |=> cpu_ready; endproperty
	a_rdy: assert property (p_rdy) else $error("processor held off");
	property p_hit; !cpu_rd |=> !cpu_hit && $stable(cpu_rdata); endproperty
	a_hit: assert property (p_hit) else $error("cpu read moved");
	property p_dma; !dma_rd |=> $stable(dma_rdata); endproperty
	a_dma: assert property (p_dma) else $error("dma read moved");
	property p_byt; cpu_rd && cpu_byte |=> cpu_rdata[15:8] == 8'h00; endproperty
	a_byt: assert property (p_byt) else $error("byte read high");
	property p_dbyt; dma_rd && dma_byte |=> dma_rdata[15:8] == 8'h00; endproperty
	a_dbyt: assert property (p_dbyt) else $error("dma byte read high");
	property p_oow; cpu_rd && !cpu_in |=> !cpu_hit && cpu_rdata == DPRAM_ZERO_WORD; endproperty
	a_oow: assert property (p_oow) else $error("miss read not zero");
	property p_inw; cpu_rd && cpu_in |=> cpu_hit; endproperty
	a_inw: assert property (p_inw) else $error("hit flag missing");
	property p_raw; s_word_wr ##1 s_word_rd_same |=> cpu_rdata == $past(cpu_wdata, 2); endproperty
	a_raw: assert property (p_raw) else $error("written word not read back");
endmodule : dpram_chk
bind dpram_core dpram_chk #(
	.SIZE_BYTES(SIZE_BYTES)
) dpram_chk_inst (
	.clk(clk),
	.rst(rst),
	.cpu_effective_byte_address(cpu_effective_byte_address),
	.cpu_rd(cpu_rd),
	.cpu_wr(cpu_wr),
	.cpu_byte(cpu_byte),
	.cpu_wdata(cpu_wdata),
	.cpu_rdata(cpu_rdata),
	.cpu_hit(cpu_hit),
	.cpu_ready(cpu_ready),
	.dma_rd(dma_rd),
	.dma_byte(dma_byte),
	.dma_rdata(dma_rdata)
);

// ---- dv/dpram_dma_model.sv ----
// dma-side partner model: xfer makes one access on the shared clock
// assumes the ram samples its dma inputs at the rising edge of clk
`timescale 1ns/100ps
module dpram_dma_model (
	input wire logic clk,
	output logic dma_rd,
	output logic dma_wr,
	output logic dma_byte,
	output logic [15:0] dma_effective_byte_address,
	output logic [15:0] dma_wdata
);
	// idle bus until the first transfer
	initial begin
		{dma_rd, dma_wr, dma_byte} = 3'h0;
		{dma_effective_byte_address, dma_wdata} = 32'h0000_0000;
	end
	// hold the request over one rising edge, then release with the bus inverted
	task automatic xfer(input logic w, b, input logic [15:0] a, d);
		@(negedge clk);
		{dma_rd, dma_wr, dma_byte} = {!w, w, b};
		{dma_effective_byte_address, dma_wdata} = {a, d};
		@(negedge clk);
		{dma_rd, dma_wr} = 2'h0;
		{dma_effective_byte_address, dma_wdata} = ~{a, d};
	endtask : xfer
endmodule : dpram_dma_model

// ---- dv/tb.sv ----
// bench for dpram_core, small variant, with the dma model
`timescale 1ns/100ps
module tb;
	import dpram_pkg::*;
	localparam logic [15:0] B = DPRAM_SPACE_TOP - 16'(DPRAM_SIZE_SMALL);
	logic clk = 0, rst = 1, cpu_rd = 0, cpu_wr = 0, cpu_byte = 0, cpu_hit, cpu_ready;
	logic dma_rd, dma_wr, dma_byte;
	logic [15:0] cpu_effective_byte_address = '0, cpu_wdata = '0, cpu_rdata, dma_rdata;
	logic [15:0] dma_effective_byte_address, dma_wdata;
	int mismatches = 0, n_compared = 0;
	// clock, ram, dma side
	always #5 clk = ~clk;
	dpram_core #(
		.SIZE_BYTES(DPRAM_SIZE_SMALL)
	) dpram_core_inst (
		.clk(clk),
		.rst(rst),
		.cpu_effective_byte_address(cpu_effective_byte_address),
		.cpu_rd(cpu_rd),
		.cpu_wr(cpu_wr),
		.cpu_byte(cpu_byte),
		.cpu_wdata(cpu_wdata),
		.cpu_rdata(cpu_rdata),
		.cpu_hit(cpu_hit),
		.dma_effective_byte_address(dma_effective_byte_address),
		.dma_rd(dma_rd),
		.dma_wr(dma_wr),
		.dma_byte(dma_byte),
		.dma_wdata(dma_wdata),
		.dma_rdata(dma_rdata),
		.cpu_ready(cpu_ready)
	);
	dpram_dma_model dpram_dma_model_inst (
		.clk(clk),
		.dma_rd(dma_rd),
		.dma_wr(dma_wr),
		.dma_byte(dma_byte),
		.dma_effective_byte_address(dma_effective_byte_address),
		.dma_wdata(dma_wdata)
	);
	// one compare: counts it, reports a mismatch
	task automatic c(input logic [15:0] g, e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : c
	task automatic op(input logic w, b, input logic [15:0] a, d);
		@(negedge clk) {cpu_rd, cpu_wr, cpu_byte} = {!w, w, b};
		{cpu_effective_byte_address, cpu_wdata} = {a, d};
		@(negedge clk) {cpu_rd, cpu_wr} = 2'b00;
	endtask : op
	task automatic t_cpu;
		op(1, 0, B, 16'h1234);
		op(0, 0, B, '0);
		c(cpu_rdata, 16'h1234);
		op(1, 1, B + 16'h0001, 16'h00AB);
		op(0, 0, B, '0);
		c(cpu_rdata, 16'hAB34);
		op(1, 0, B - 16'h0002, 16'hFFFF);
		op(0, 1, B - 16'h0001, '0);
		c(cpu_rdata, 16'h0000);
		$display("cpu test done");
	endtask : t_cpu
	task automatic t_two;
		fork
			op(1, 0, B + 16'h0002, 16'h5A5A);
			dpram_dma_model_inst.xfer(1, 0, B + 16'h0002, 16'hC3C3);
		join
		fork
			op(0, 0, B + 16'h0002, '0);
			dpram_dma_model_inst.xfer(0, 1, B + 16'h0003, '0);
		join
		c(cpu_rdata, 16'h5A5A);
		c(dma_rdata, 16'h005A);
		$display("two-port test done");
	endtask : t_two
	// word write and word read of one address on consecutive edges
	task automatic t_b2b;
		@(negedge clk);
		{cpu_wr, cpu_byte} = 2'h2;
		{cpu_effective_byte_address, cpu_wdata} = {B + 16'h0006, 16'h6C6C};
		@(negedge clk);
		{cpu_rd, cpu_wr} = 2'h2;
		@(negedge clk);
		cpu_rd = 1'b0;
		c(cpu_rdata, 16'h6C6C);
		c(16'(cpu_hit), 16'h0001);
		$display("back-to-back test done");
	endtask : t_b2b
	// dma writes, split-lane collision, misses on both ports, ready
	task automatic t_dma;
		dpram_dma_model_inst.xfer(1, 0, B + 16'h0004, 16'hBEEF);
		op(0, 0, B + 16'h0004, '0);
		c(cpu_rdata, 16'hBEEF);
		c(16'(cpu_hit), 16'h0001);
		fork
			op(1, 1, B + 16'h0004, 16'h0011);
			dpram_dma_model_inst.xfer(1, 1, B + 16'h0005, 16'h0022);
		join
		op(0, 0, B + 16'h0004, '0);
		c(cpu_rdata, 16'h2211);
		op(0, 0, B - 16'h0002, '0);
		c(cpu_rdata, 16'h0000);
		c(16'(cpu_hit), 16'h0000);
		dpram_dma_model_inst.xfer(0, 0, B - 16'h0002, '0);
		c(dma_rdata, 16'h0000);
		c(16'(cpu_ready), 16'h0001);
		$display("dma test done");
	endtask : t_dma
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test
	// reset, tests, verdict
	initial begin
		repeat (5) @(negedge clk);
		rst = 0;
		t_cpu;
		t_two;
		t_b2b;
		t_dma;
		finish_test;
	end
	// watchdog
	initial begin
		#3000;
		mismatches++;
		finish_test;
	end
endmodule : tb

// ---- rtl/dpram_core.sv ----
// dual-ported transfer ram at the top of the implemented data space
// assumes processor and dma controller share clk; both ports have registered read data
// Function
// - ram is 1 KB or 2 KB, chosen by a size parameter
// - ram sits at the highest addresses of the main data space
// - processor and dma ports each complete an access in the same cycle
// - dma access never stalls the processor; no wait states
// - same-location simultaneous writes: processor value is stored
// - 16-bit words, low byte at even address, high byte at odd
// - byte write changes only the lane picked by address bit 0
// - byte read returns selected byte in the low byte of read data
`timescale 1ns/100ps
module dpram_core #(
	parameter int unsigned SIZE_BYTES = dpram_pkg::DPRAM_SIZE_LARGE
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [dpram_pkg::DPRAM_ADDR_W-1:0] cpu_effective_byte_address,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic cpu_byte,
	input wire logic [dpram_pkg::DPRAM_DATA_W-1:0] cpu_wdata,
	output logic [dpram_pkg::DPRAM_DATA_W-1:0] cpu_rdata,
	output logic cpu_hit,
	input wire logic [dpram_pkg::DPRAM_ADDR_W-1:0] dma_effective_byte_address,
	input wire logic dma_rd,
	input wire logic dma_wr,
	input wire logic dma_byte,
	input wire logic [dpram_pkg::DPRAM_DATA_W-1:0] dma_wdata,
	output logic [dpram_pkg::DPRAM_DATA_W-1:0] dma_rdata,
	output logic cpu_ready
);
	import dpram_pkg::*;

	// ***************************************************
	// sizing
	// ***************************************************
	// words held by the ram
	localparam int unsigned WORDS = SIZE_BYTES / DPRAM_BYTES_PER_WORD;
	// bits of the word index within the window
	localparam int unsigned IDX_W = $clog2(WORDS);
	localparam int unsigned IDX_MSB = DPRAM_IDX_LSB + IDX_W - 1;
	// lowest byte address of the window; the window ends at the space top
	localparam logic [DPRAM_ADDR_W-1:0] BASE =
		DPRAM_ADDR_W'(32'(DPRAM_SPACE_TOP) - SIZE_BYTES);

	// ***************************************************
	// declarations
	// ***************************************************
	// window decode per port
	logic cpu_in;
	logic dma_in;
	// word index per port
	logic [IDX_W-1:0] cpu_idx;
	logic [IDX_W-1:0] dma_idx;
	// lane write strobes, dma before and after collision masking
	logic [DPRAM_LANES-1:0] cpu_we;
	logic [DPRAM_LANES-1:0] dma_we_raw;
	logic [DPRAM_LANES-1:0] dma_we;
	// write data with a byte copied to both lanes
	logic [DPRAM_DATA_W-1:0] cpu_wd;
	logic [DPRAM_DATA_W-1:0] dma_wd;
	// stored words as seen before this edge's writes
	logic [DPRAM_DATA_W-1:0] cpu_word;
	logic [DPRAM_DATA_W-1:0] dma_word;
	// processor read state
	logic [DPRAM_DATA_W-1:0] cpu_rdata_q;
	logic [DPRAM_DATA_W-1:0] cpu_rdata_d;
	logic cpu_hit_q;
	logic cpu_hit_d;
	// dma read state
	logic [DPRAM_DATA_W-1:0] dma_rdata_q;
	logic [DPRAM_DATA_W-1:0] dma_rdata_d;
	// processor ready state
	logic cpu_ready_q;
	logic cpu_ready_d;

	// ***************************************************
	// helpers
	// ***************************************************
	// lanes that one write touches: both for a word, one for a byte
	function automatic logic [DPRAM_LANES-1:0] lane_mask(input logic wr, input logic hit,
		input logic is_byte, input logic odd);
		lane_mask = DPRAM_LANE_NONE;
		if (wr && hit) begin
			if (!is_byte) begin
				lane_mask = DPRAM_LANE_BOTH;
			end else if (odd) begin
				lane_mask = DPRAM_LANE_HI;
			end else begin
				lane_mask = DPRAM_LANE_LO;
			end
		end
	endfunction : lane_mask

	// write data laid onto the lanes; a byte goes to both, the strobe picks one
	function automatic logic [DPRAM_DATA_W-1:0] lane_data(input logic is_byte,
		input logic [DPRAM_DATA_W-1:0] wdata);
		if (is_byte) begin
			lane_data = {wdata[DPRAM_BYTE_W-1:0], wdata[DPRAM_BYTE_W-1:0]};
		end else begin
			lane_data = wdata;
		end
	endfunction : lane_data

	// read word narrowed to one byte, zero-filled above, when a byte is asked for
	function automatic logic [DPRAM_DATA_W-1:0] read_pick(input logic is_byte,
		input logic odd, input logic [DPRAM_DATA_W-1:0] word);
		read_pick = word;
		if (is_byte) begin
			read_pick = {DPRAM_ZERO_BYTE, odd ? word[DPRAM_DATA_W-1:DPRAM_BYTE_W] :
				word[DPRAM_BYTE_W-1:0]};
		end
	endfunction : read_pick

	// ***************************************************
	// decode
	// ***************************************************
	// window hit and word index for both ports
	always_comb begin
		cpu_in = (cpu_effective_byte_address >= BASE) &&
			(cpu_effective_byte_address < DPRAM_SPACE_TOP);
		dma_in = (dma_effective_byte_address >= BASE) &&
			(dma_effective_byte_address < DPRAM_SPACE_TOP);
		cpu_idx = cpu_effective_byte_address[IDX_MSB:DPRAM_IDX_LSB];
		dma_idx = dma_effective_byte_address[IDX_MSB:DPRAM_IDX_LSB];
	end

	// ***************************************************
	// write path
	// ***************************************************
	// lane strobes; on a shared word the dma loses every lane the processor writes
	always_comb begin
		cpu_we = lane_mask(cpu_wr, cpu_in, cpu_byte,
			cpu_effective_byte_address[DPRAM_LANE_BIT]);
		dma_we_raw = lane_mask(dma_wr, dma_in, dma_byte,
			dma_effective_byte_address[DPRAM_LANE_BIT]);
		dma_we = dma_we_raw;
		if (cpu_idx == dma_idx) begin
			dma_we = dma_we_raw & ~cpu_we;
		end
		cpu_wd = lane_data(cpu_byte, cpu_wdata);
		dma_wd = lane_data(dma_byte, dma_wdata);
	end

	// ***************************************************
	// storage
	// ***************************************************
	// one byte-wide array per lane: shared word decode, separate write strobes
	for (genvar l = 0; l < DPRAM_LANES; l++) begin : g_lane
		logic [DPRAM_BYTE_W-1:0] lane_q [WORDS];

		// dma first, processor last: the processor byte is the one kept
		always_ff @(posedge clk) begin
			if (dma_we[l]) begin
				lane_q[dma_idx] <= dma_wd[l*DPRAM_BYTE_W +: DPRAM_BYTE_W];
			end
			if (cpu_we[l]) begin
				lane_q[cpu_idx] <= cpu_wd[l*DPRAM_BYTE_W +: DPRAM_BYTE_W];
			end
		end

		// both ports read the old contents in the same cycle
		assign cpu_word[l*DPRAM_BYTE_W +: DPRAM_BYTE_W] = lane_q[cpu_idx];
		assign dma_word[l*DPRAM_BYTE_W +: DPRAM_BYTE_W] = lane_q[dma_idx];
	end

	// ***************************************************
	// read path
	// ***************************************************
	// processor read: window miss reads zero, data holds between reads
	always_comb begin
		cpu_rdata_d = cpu_rdata_q;
		cpu_hit_d = cpu_rd && cpu_in;
		if (cpu_rd && !cpu_in) begin
			cpu_rdata_d = DPRAM_ZERO_WORD;
		end else if (cpu_rd) begin
			cpu_rdata_d = read_pick(cpu_byte, cpu_effective_byte_address[DPRAM_LANE_BIT],
				cpu_word);
		end
	end

	// processor read registers
	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_rdata_q <= DPRAM_ZERO_WORD;
			cpu_hit_q <= 1'b0;
		end else begin
			cpu_rdata_q <= cpu_rdata_d;
			cpu_hit_q <= cpu_hit_d;
		end
	end

	// dma read: same rules as the processor, no hit flag
	always_comb begin
		dma_rdata_d = dma_rdata_q;
		if (dma_rd && !dma_in) begin
			dma_rdata_d = DPRAM_ZERO_WORD;
		end else if (dma_rd) begin
			dma_rdata_d = read_pick(dma_byte, dma_effective_byte_address[DPRAM_LANE_BIT],
				dma_word);
		end
	end

	// dma read register
	always_ff @(posedge clk) begin
		if (rst) begin
			dma_rdata_q <= DPRAM_ZERO_WORD;
		end else begin
			dma_rdata_q <= dma_rdata_d;
		end
	end

	// ***************************************************
	// ready
	// ***************************************************
	// the ram never adds a wait state, so ready only drops in reset
	always_comb begin
		cpu_ready_d = 1'b1;
	end

	// ready register
	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_ready_q <= 1'b0;
		end else begin
			cpu_ready_q <= cpu_ready_d;
		end
	end

	// ***************************************************
	// outputs
	// ***************************************************
	// outputs straight from their registers
	assign cpu_rdata = cpu_rdata_q;
	assign cpu_hit = cpu_hit_q;
	assign dma_rdata = dma_rdata_q;
	assign cpu_ready = cpu_ready_q;
endmodule : dpram_core

// ---- rtl/dpram_pkg.sv ----
// package for the dual-ported transfer ram
// assumes a single clock and a 16-bit byte-addressed data space
package dpram_pkg;
	localparam int unsigned DPRAM_ADDR_W = 16; // effective byte address width
	localparam int unsigned DPRAM_DATA_W = 16; // word width
	localparam int unsigned DPRAM_BYTE_W = 8;
	localparam int unsigned DPRAM_SIZE_SMALL = 1024; // bytes, smaller variant
	localparam int unsigned DPRAM_SIZE_LARGE = 2048; // bytes, larger variants
	localparam int unsigned DPRAM_LANE_BIT = 0; // address bit picking the byte lane
	localparam int unsigned DPRAM_IDX_LSB = 1; // lowest address bit of the word index
	localparam int unsigned DPRAM_BYTES_PER_WORD = 2; // bytes in one word
	localparam int unsigned DPRAM_LANES = 2; // byte lanes per word
	localparam logic [DPRAM_LANES-1:0] DPRAM_LANE_NONE = 2'h0; // no lane written
	localparam logic [DPRAM_LANES-1:0] DPRAM_LANE_LO = 2'h1; // even byte
	localparam logic [DPRAM_LANES-1:0] DPRAM_LANE_HI = 2'h2; // odd byte
	localparam logic [DPRAM_LANES-1:0] DPRAM_LANE_BOTH = 2'h3; // whole word
	localparam logic [7:0] DPRAM_ZERO_BYTE = 8'h00; // fill above a byte read
	localparam logic [15:0] DPRAM_ZERO_WORD = 16'h0000;
	localparam logic [15:0] DPRAM_SPACE_TOP = 16'h8000; // end of implemented data space
endpackage : dpram_pkg
